/* File: logic/bias_config_and_fault_flags.sv */
// Purpose: APB register bank for display bias configuration, voltage codes and fault flags.
// Assumes: Single 200 MHz clock; fault and pin inputs are asynchronous.
// Notes:   Zero-wait APB slave; unmapped or misaligned addresses answer with an error.
//
// Summary of operation
// - Primary flags read-only, zero after reset, bit7 backlight overvoltage
// - Primary bit6 flash overvoltage, zero after reset
// - Primary bits5..3: flash short, input monitor, flash interrupt
// - Primary bits2..0: LED short, timeout, thermal
// - Secondary read-only; 7..6 reserved; panel boost, negative overvoltage
// - Secondary bit3 positive short, bit2 negative short
// - Secondary bit1 flash overcurrent, bit0 backlight overcurrent
// - Config bit7 enables wake-up mode, default off
// - Config bit6 picks ramp: 800us or 500us
// - Config bit5 enables auto-sequencing, default off
// - Config bit4 positive active discharge, default on
// - Config bit3 negative active discharge, default on
// - Config bits2,1 enable positive, negative rails, default off
// - Config bit0 chooses pins or register bits
// - Panel boost code six bits, reset 011110
// - Positive rail code six bits, reset 011110
// - Negative rail code six bits, reset 011100
`timescale 1ns/1ps
`include "bias_params.svh"
module bias_config_and_fault_flags #(
	parameter int RAMP_SLOW_CYCLES = `POS_RAMP_SLOW_US * `CLOCK_MHZ,
	parameter int RAMP_FAST_CYCLES = `POS_RAMP_FAST_US * `CLOCK_MHZ
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Interrupt
	output logic IRQ_O,
	// Fault inputs from the analog side
	input wire logic BACKLIGHT_OVERVOLTAGE_FLAG_I,
	input wire logic FLASH_OVERVOLTAGE_FLAG_I,
	input wire logic FLASH_OUTPUT_SHORT_FLAG_I,
	input wire logic INPUT_MONITOR_FLAG_I,
	input wire logic FLASH_INTERRUPT_FLAG_I,
	input wire logic FLASH_LED_SHORT_FLAG_I,
	input wire logic FLASH_TIMEOUT_FLAG_I,
	input wire logic THERMAL_SHUTDOWN_FLAG_I,
	input wire logic PANEL_BOOST_OVERVOLTAGE_FLAG_I,
	input wire logic NEGATIVE_RAIL_OVERVOLTAGE_FLAG_I,
	input wire logic POSITIVE_RAIL_SHORT_FLAG_I,
	input wire logic NEGATIVE_RAIL_SHORT_FLAG_I,
	input wire logic FLASH_OVERCURRENT_FLAG_I,
	input wire logic BACKLIGHT_OVERCURRENT_FLAG_I,
	// External rail enable pins
	input wire logic POSITIVE_RAIL_ENABLE_PIN_I,
	input wire logic NEGATIVE_RAIL_ENABLE_PIN_I,
	// Rail controls to the analog side
	output logic POSITIVE_RAIL_ON_O,
	output logic POSITIVE_RAIL_RAMPING_O,
	output logic NEGATIVE_RAIL_ON_O,
	output logic POSITIVE_DISCHARGE_O,
	output logic NEGATIVE_DISCHARGE_O,
	output logic POSITIVE_RAMP_TIME_SELECT_O,
	output logic WAKE_UP_ENABLE_O,
	output logic AUTO_SEQUENCE_ENABLE_O,
	// Voltage codes
	output logic [`VCODE_W-1:0] PANEL_BOOST_VOLTAGE_FIELD_O,
	output logic [`VCODE_W-1:0] POSITIVE_RAIL_VOLTAGE_FIELD_O,
	output logic [`VCODE_W-1:0] NEGATIVE_RAIL_VOLTAGE_FIELD_O
);

	// ----------------------------------------
	// State
	// ----------------------------------------

	typedef struct packed {
		logic [31:0] rdata;
		logic [7:0] cfg;
		logic [`VCODE_W-1:0] panel_code;
		logic [`VCODE_W-1:0] pos_code;
		logic [`VCODE_W-1:0] neg_code;
		logic [`IRQ_W-1:0] irq_enable;
		logic irq;
	} bank_t;

	bank_t q;
	bank_t d;

	// ----------------------------------------
	// Wires
	// ----------------------------------------

	logic [`FLAGS_PRI_W-1:0] flags_pri;
	logic [`FLAGS_SEC_W-1:0] flags_sec;
	logic [`FLAGS_PRI_W-1:0] fault_pri;
	logic [`FLAGS_SEC_W-1:0] fault_sec;
	logic [`IRQ_W-1:0] irq_status;
	logic [`IRQ_W-1:0] irq_clear;
	logic [5:0] word_idx;
	logic aligned;
	logic mapped;
	logic setup;
	logic access;
	logic wr_en;
	logic byte0;
	logic byte1;
	logic pos_on;
	logic pos_ramping;
	logic neg_on;
	logic pos_dis;
	logic neg_dis;
	logic [31:0] read_mux;

	// ----------------------------------------
	// Fault inputs in flag-register bit order
	// ----------------------------------------

	// Primary flags, bit 7 down to bit 0
	assign fault_pri = {
		BACKLIGHT_OVERVOLTAGE_FLAG_I,
		FLASH_OVERVOLTAGE_FLAG_I,
		FLASH_OUTPUT_SHORT_FLAG_I,
		INPUT_MONITOR_FLAG_I,
		FLASH_INTERRUPT_FLAG_I,
		FLASH_LED_SHORT_FLAG_I,
		FLASH_TIMEOUT_FLAG_I,
		THERMAL_SHUTDOWN_FLAG_I
	};

	// Secondary flags, bit 5 down to bit 0
	assign fault_sec = {
		PANEL_BOOST_OVERVOLTAGE_FLAG_I,
		NEGATIVE_RAIL_OVERVOLTAGE_FLAG_I,
		POSITIVE_RAIL_SHORT_FLAG_I,
		NEGATIVE_RAIL_SHORT_FLAG_I,
		FLASH_OVERCURRENT_FLAG_I,
		BACKLIGHT_OVERCURRENT_FLAG_I
	};

	// ----------------------------------------
	// APB decode
	// ----------------------------------------

	// Zero-wait slave: every access phase completes in one cycle
	assign PREADY_O = 1'b1;
	assign word_idx = PADDR_I[7:2];
	assign aligned = (PADDR_I[1:0] == 2'b00);
	assign setup = PSEL_I & !PENABLE_I;
	assign access = PSEL_I & PENABLE_I;
	assign byte0 = PSTRB_I[0];
	assign byte1 = PSTRB_I[1];

	// Address hit; misaligned bytes within a word are treated as unmapped
	always_comb begin
		unique case (word_idx)
			`REG_IDX_FLAGS_PRI,
			`REG_IDX_BIAS_CFG,
			`REG_IDX_PANEL_CODE,
			`REG_IDX_POS_CODE,
			`REG_IDX_NEG_CODE,
			`REG_IDX_FLAGS_SEC,
			`REG_IDX_IRQ_CLEAR,
			`REG_IDX_IRQ_ENABLE,
			`REG_IDX_RAIL_STATUS: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	// Error only on the access phase so the setup cycle shows nothing
	assign PSLVERR_O = access & !mapped;
	assign wr_en = access & PWRITE_I & mapped;

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------

	// Reserved and write-only bits read as zero
	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (word_idx)
			`REG_IDX_FLAGS_PRI: read_mux[7:0] = flags_pri;
			`REG_IDX_BIAS_CFG: read_mux[7:0] = q.cfg;
			`REG_IDX_PANEL_CODE: read_mux[`VCODE_W-1:0] = q.panel_code;
			`REG_IDX_POS_CODE: read_mux[`VCODE_W-1:0] = q.pos_code;
			`REG_IDX_NEG_CODE: read_mux[`VCODE_W-1:0] = q.neg_code;
			`REG_IDX_FLAGS_SEC: read_mux[`FLAGS_SEC_W-1:0] = flags_sec;
			`REG_IDX_IRQ_ENABLE: read_mux[`IRQ_W-1:0] = q.irq_enable;
			`REG_IDX_RAIL_STATUS: read_mux[3:0] = {pos_ramping, neg_on, pos_on, q.irq};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Interrupt clear
	// ----------------------------------------

	// One-cycle clear mask; sticky flags give way unless the fault still holds
	always_comb begin
		irq_clear = '0;
		if (wr_en && word_idx == `REG_IDX_IRQ_CLEAR) begin
			if (byte0) begin
				irq_clear[7:0] = PWDATA_I[7:0];
			end
			if (byte1) begin
				irq_clear[`IRQ_W-1:8] = PWDATA_I[`IRQ_W-1:8];
			end
		end
	end

	assign irq_status = {flags_sec, flags_pri};

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	// Read data is latched in the setup cycle, so it is a flop output in the access phase
	always_comb begin
		d = q;
		if (setup) begin
			d.rdata = (mapped && !PWRITE_I) ? read_mux : 32'h0000_0000;
		end
		if (wr_en && byte0) begin
			unique case (word_idx)
				`REG_IDX_BIAS_CFG: d.cfg = PWDATA_I[7:0];
				`REG_IDX_PANEL_CODE: d.panel_code = PWDATA_I[`VCODE_W-1:0];
				`REG_IDX_POS_CODE: d.pos_code = PWDATA_I[`VCODE_W-1:0];
				`REG_IDX_NEG_CODE: d.neg_code = PWDATA_I[`VCODE_W-1:0];
				`REG_IDX_IRQ_ENABLE: d.irq_enable[7:0] = PWDATA_I[7:0];
				// Flag registers, clear and status: no stored write effect
				default: d.cfg = q.cfg;
			endcase
		end
		if (wr_en && byte1 && word_idx == `REG_IDX_IRQ_ENABLE) begin
			d.irq_enable[`IRQ_W-1:8] = PWDATA_I[`IRQ_W-1:8];
		end
		// Level interrupt while any enabled sticky flag stands
		d.irq = |(irq_status & q.irq_enable);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------

	// Reset values of the configuration and code registers
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			q.rdata <= 32'h0000_0000;
			q.cfg <= `BIAS_CFG_RST;
			q.panel_code <= `PANEL_CODE_RST;
			q.pos_code <= `POS_CODE_RST;
			q.neg_code <= `NEG_CODE_RST;
			q.irq_enable <= '0;
			q.irq <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Fault capture
	// ----------------------------------------

	// Primary fault flags, zero from reset
	fault_capture #(
		.WIDTH(`FLAGS_PRI_W)
	) u_flags_pri (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.fault_i(fault_pri),
		.clear_i(irq_clear[7:0]),
		.flags_o(flags_pri)
	);

	// Secondary fault flags, zero from reset
	fault_capture #(
		.WIDTH(`FLAGS_SEC_W)
	) u_flags_sec (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.fault_i(fault_sec),
		.clear_i(irq_clear[`IRQ_W-1:8]),
		.flags_o(flags_sec)
	);

	// ----------------------------------------
	// Rail enable and ramp
	// ----------------------------------------

	// Enable source, discharge and ramp timing follow the configuration register
	rail_enable #(
		.RAMP_SLOW_CYCLES(RAMP_SLOW_CYCLES),
		.RAMP_FAST_CYCLES(RAMP_FAST_CYCLES)
	) u_rails (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.cfg_i(q.cfg),
		.positive_rail_enable_pin_i(POSITIVE_RAIL_ENABLE_PIN_I),
		.negative_rail_enable_pin_i(NEGATIVE_RAIL_ENABLE_PIN_I),
		.pos_on_o(pos_on),
		.pos_ramping_o(pos_ramping),
		.neg_on_o(neg_on),
		.pos_discharge_o(pos_dis),
		.neg_discharge_o(neg_dis)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Bus and interrupt
	assign PRDATA_O = q.rdata;
	assign IRQ_O = q.irq;

	// Rail controls
	assign POSITIVE_RAIL_ON_O = pos_on;
	assign POSITIVE_RAIL_RAMPING_O = pos_ramping;
	assign NEGATIVE_RAIL_ON_O = neg_on;
	assign POSITIVE_DISCHARGE_O = pos_dis;
	assign NEGATIVE_DISCHARGE_O = neg_dis;

	// Mode bits straight from the configuration register
	assign POSITIVE_RAMP_TIME_SELECT_O = q.cfg[`CFG_RAMP_SEL];
	assign WAKE_UP_ENABLE_O = q.cfg[`CFG_WAKE];
	assign AUTO_SEQUENCE_ENABLE_O = q.cfg[`CFG_AUTO_SEQUENCE_ENABLE];

	// Voltage codes; the analog side scales them per step
	assign PANEL_BOOST_VOLTAGE_FIELD_O = q.panel_code;
	assign POSITIVE_RAIL_VOLTAGE_FIELD_O = q.pos_code;
	assign NEGATIVE_RAIL_VOLTAGE_FIELD_O = q.neg_code;

endmodule : bias_config_and_fault_flags

/* File: logic/bias_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the bias register bank.
// Assumes: Register indexes are word indexes; byte address is four times the index.
// Notes:   Definitions only.
`ifndef BIAS_PARAMS_SVH
`define BIAS_PARAMS_SVH
// ----------------------------------------
// Register indexes
// ----------------------------------------
`define REG_IDX_FLAGS_PRI 6'h0B
`define REG_IDX_BIAS_CFG 6'h0C
`define REG_IDX_PANEL_CODE 6'h0D
`define REG_IDX_POS_CODE 6'h0E
`define REG_IDX_NEG_CODE 6'h0F
`define REG_IDX_FLAGS_SEC 6'h10
`define REG_IDX_IRQ_CLEAR 6'h11
`define REG_IDX_IRQ_ENABLE 6'h12
`define REG_IDX_RAIL_STATUS 6'h13
// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define BIAS_CFG_RST 8'h18
`define PANEL_CODE_RST 6'h1E
`define POS_CODE_RST 6'h1E
`define NEG_CODE_RST 6'h1C
`define VCODE_W 6
`define FLAGS_PRI_W 8
`define FLAGS_SEC_W 6
`define IRQ_W 14
// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define CFG_WAKE 7
`define CFG_RAMP_SEL 6
`define CFG_AUTO_SEQUENCE_ENABLE 5
`define CFG_POS_DIS 4
`define CFG_NEG_DIS 3
`define CFG_POS_EN 2
`define CFG_NEG_EN 1
`define CFG_PIN_SEL 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_MHZ 200
`define POS_RAMP_SLOW_US 800
`define POS_RAMP_FAST_US 500
`endif

/* File: logic/bias_pkg.sv */
// Purpose: Types shared by the bias register bank.
// Assumes: Constants live in bias_params.svh.
// Notes:   One-hot codes written out.
package bias_pkg;
	// ----------------------------------------
	// Positive rail ramp states
	// ----------------------------------------
	typedef enum logic [2:0] {
		RAIL_OFF = 3'b001,
		RAIL_RAMP = 3'b010,
		RAIL_ON = 3'b100
	} rail_state_t;
endpackage : bias_pkg

/* File: logic/fault_capture.sv */
// Purpose: Synchronise fault inputs and hold them as sticky flags.
// Assumes: Fault inputs are asynchronous levels from the analog side.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/1ps
module fault_capture #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fault levels and clear mask
	input wire logic [WIDTH-1:0] fault_i,
	input wire logic [WIDTH-1:0] clear_i,
	// Sticky flags
	output logic [WIDTH-1:0] flags_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] sticky;
	} cap_t;
	cap_t q;
	cap_t d;
	// Level only moves once stages two and three agree, filtering one-cycle metastable glitches
	always_comb begin
		d = q;
		d.s1 = fault_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.level = (q.s2 & q.s3) | (q.level & (q.s2 | q.s3));
		d.sticky = (q.sticky & ~clear_i) | q.level;
	end
	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign flags_o = q.sticky;
endmodule : fault_capture

/* File: logic/rail_enable.sv */
// Purpose: Pick the enable source of each bias rail and time the positive rail ramp.
// Assumes: Enable pins are asynchronous levels.
// Notes:   Ramp counts are parameters so a simulation can shorten them.
`timescale 1ns/1ps
`include "bias_params.svh"
module rail_enable #(
	parameter int RAMP_SLOW_CYCLES = `POS_RAMP_SLOW_US * `CLOCK_MHZ,
	parameter int RAMP_FAST_CYCLES = `POS_RAMP_FAST_US * `CLOCK_MHZ
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Configuration and pins
	input wire logic [7:0] cfg_i,
	input wire logic positive_rail_enable_pin_i,
	input wire logic negative_rail_enable_pin_i,
	// Rail controls
	output logic pos_on_o,
	output logic pos_ramping_o,
	output logic neg_on_o,
	output logic pos_discharge_o,
	output logic neg_discharge_o
);
	localparam int CW = $clog2(RAMP_SLOW_CYCLES + 1);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] pin;
		bias_pkg::rail_state_t state;
		logic [CW-1:0] count;
	} rail_t;
	rail_t q;
	rail_t d;
	logic pos_req;
	logic neg_req;
	// Source select: pins only or register bits only, never a mix
	assign pos_req = cfg_i[`CFG_PIN_SEL] ? q.pin[0] : cfg_i[`CFG_POS_EN];
	assign neg_req = cfg_i[`CFG_PIN_SEL] ? q.pin[1] : cfg_i[`CFG_NEG_EN];
	// Pin filter and ramp sequencer
	always_comb begin
		d = q;
		d.s1 = {negative_rail_enable_pin_i, positive_rail_enable_pin_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pin = (q.s2 & q.s3) | (q.pin & (q.s2 | q.s3));
		unique case (q.state)
			bias_pkg::RAIL_OFF: begin
				if (pos_req) begin
					d.state = bias_pkg::RAIL_RAMP;
					d.count = cfg_i[`CFG_RAMP_SEL] ? CW'(RAMP_FAST_CYCLES - 1) : CW'(RAMP_SLOW_CYCLES - 1);
				end
			end
			bias_pkg::RAIL_RAMP: begin
				if (!pos_req) begin
					d.state = bias_pkg::RAIL_OFF;
				end else if (q.count == '0) begin
					d.state = bias_pkg::RAIL_ON;
				end else begin
					d.count = q.count - CW'(1);
				end
			end
			bias_pkg::RAIL_ON: begin
				if (!pos_req) begin
					d.state = bias_pkg::RAIL_OFF;
				end
			end
		endcase
	end
	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{s1: '0, s2: '0, s3: '0, pin: '0, state: bias_pkg::RAIL_OFF, count: '0};
		end else begin
			q <= d;
		end
	end
	// Outputs; under auto-sequencing the negative rail waits for the positive ramp
	assign pos_on_o = (q.state != bias_pkg::RAIL_OFF);
	assign pos_ramping_o = (q.state == bias_pkg::RAIL_RAMP);
	assign neg_on_o = neg_req & (!cfg_i[`CFG_AUTO_SEQUENCE_ENABLE] | (q.state == bias_pkg::RAIL_ON));
	assign pos_discharge_o = !pos_on_o & cfg_i[`CFG_POS_DIS];
	assign neg_discharge_o = !neg_on_o & cfg_i[`CFG_NEG_DIS];
endmodule : rail_enable

/* File: testbench/bias_bank_assertions.sv */
// Purpose: Port-level checks of the bias register bank.
// Assumes: Zero-wait APB; configuration word at byte 0x30.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`include "bias_params.svh"
module bias_bank_checker #(
	parameter int RAMP_SLOW_CYCLES = 20
) (
	// Clock, reset, APB and pin
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic NEGATIVE_RAIL_ENABLE_PIN_I,
	// Design outputs
	input wire logic POSITIVE_RAIL_ON_O,
	input wire logic POSITIVE_RAIL_RAMPING_O,
	input wire logic NEGATIVE_RAIL_ON_O,
	input wire logic POSITIVE_DISCHARGE_O,
	input wire logic NEGATIVE_DISCHARGE_O,
	input wire logic POSITIVE_RAMP_TIME_SELECT_O,
	input wire logic WAKE_UP_ENABLE_O,
	input wire logic AUTO_SEQUENCE_ENABLE_O,
	input wire logic [`VCODE_W-1:0] PANEL_BOOST_VOLTAGE_FIELD_O,
	input wire logic [`VCODE_W-1:0] POSITIVE_RAIL_VOLTAGE_FIELD_O,
	input wire logic [`VCODE_W-1:0] NEGATIVE_RAIL_VOLTAGE_FIELD_O
);
	// Pin-low run and ramp length; the pin filter needs several cycles to settle
	logic [2:0] pin_low_q;
	int ramp_q;
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pin_low_q <= 3'h0;
			ramp_q <= 0;
		end else begin
			pin_low_q <= NEGATIVE_RAIL_ENABLE_PIN_I ? 3'h0 : ((pin_low_q == 3'h7) ? pin_low_q : pin_low_q + 3'h1);
			ramp_q <= POSITIVE_RAIL_RAMPING_O ? ramp_q + 1 : 0;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESET_N_I);
	sequence wr_s(logic [7:0] a);
		PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == a && PSTRB_I[0];
	endsequence
	property code_p(logic [7:0] a, logic [5:0] f);
		wr_s(a) |=> f == $past(PWDATA_I[5:0]);
	endproperty
	chk_wake_bit: assert property (wr_s(8'h30) |=> WAKE_UP_ENABLE_O == $past(PWDATA_I[7]))
		else $error("wake-up bit not loaded");
	chk_ramp_bit: assert property (wr_s(8'h30) |=> POSITIVE_RAMP_TIME_SELECT_O == $past(PWDATA_I[6]))
		else $error("ramp select bit not loaded");
	chk_ramp_bound: assert property (POSITIVE_RAIL_RAMPING_O |-> ramp_q <= RAMP_SLOW_CYCLES + 1)
		else $error("ramp ran too long");
	chk_seq_bit: assert property (wr_s(8'h30) |=> AUTO_SEQUENCE_ENABLE_O == $past(PWDATA_I[5]))
		else $error("auto-sequence bit not loaded");
	chk_pos_disch: assert property (wr_s(8'h30) ##0 PWDATA_I[2] == 1'b0 && PWDATA_I[0] == 1'b0
		|=> ##1 POSITIVE_DISCHARGE_O == $past(PWDATA_I[4], 2)) else $error("positive discharge wrong");
	chk_neg_disch: assert property (wr_s(8'h30) ##0 PWDATA_I[1:0] == 2'b00
		|=> NEGATIVE_DISCHARGE_O == $past(PWDATA_I[3])) else $error("negative discharge wrong");
	chk_pos_enable: assert property (wr_s(8'h30) ##0 PWDATA_I[0] == 1'b0
		|=> ##1 POSITIVE_RAIL_ON_O == $past(PWDATA_I[2], 2)) else $error("positive rail enable wrong");
	chk_neg_enable: assert property (wr_s(8'h30) ##0 PWDATA_I[1:0] == 2'b10 && !PWDATA_I[5]
		|=> NEGATIVE_RAIL_ON_O) else $error("negative rail not enabled");
	chk_pin_select: assert property (wr_s(8'h30) ##0 PWDATA_I[0] && pin_low_q == 3'h7
		|=> !NEGATIVE_RAIL_ON_O) else $error("register bit used in pin mode");
	chk_panel_code: assert property (code_p(8'h34, PANEL_BOOST_VOLTAGE_FIELD_O))
		else $error("panel code not loaded");
	chk_pos_code: assert property (code_p(8'h38, POSITIVE_RAIL_VOLTAGE_FIELD_O))
		else $error("positive code not loaded");
	chk_neg_code: assert property (code_p(8'h3C, NEGATIVE_RAIL_VOLTAGE_FIELD_O))
		else $error("negative code not loaded");
endmodule : bias_bank_checker

bind bias_config_and_fault_flags bias_bank_checker #(.RAMP_SLOW_CYCLES(RAMP_SLOW_CYCLES)) chk_u (.*);

/* File: testbench/apb_host.sv */
// Purpose: Host processor model driving APB transfers.
// Assumes: One clock; signals change only just after a rising edge.
// Notes:   A wait past 64 cycles raises hung_o.
`timescale 1ns/1ps
module apb_host (
	// Clock
	input wire logic clk_i,
	// APB master side
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	output logic [3:0] pstrb_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	// Hang indicator
	output logic hung_o
);
	// Idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0000_0000;
		pstrb_o = 4'hF;
		hung_o = 1'b0;
	end
	// One transfer; request held until pready is seen at an edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		hung_o = hung_o | (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask : xfer
endmodule : apb_host

/* File: testbench/bias_config_and_fault_flags_tb_top.sv */
// Purpose: Self-checking bench of the bias register bank against a small model.
// Assumes: Ramp counts shortened to 20 and 12 cycles.
// Notes:   Flags are sticky in the model until cleared.
`timescale 1ns/1ps
`include "bias_params.svh"
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module bias_config_and_fault_flags_tb_top;
	localparam int SLOW = 20;
	localparam int FAST = 12;
	logic CLOCK_I = 1'b0;
	logic RESET_N_I = 1'b0;
	logic PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, IRQ_O, hung, pin_p, pin_n;
	logic [7:0] PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O;
	logic [3:0] PSTRB_I;
	logic [13:0] flt;
	logic POSITIVE_RAIL_ON_O, POSITIVE_RAIL_RAMPING_O, NEGATIVE_RAIL_ON_O, POSITIVE_DISCHARGE_O;
	logic NEGATIVE_DISCHARGE_O, POSITIVE_RAMP_TIME_SELECT_O, WAKE_UP_ENABLE_O, AUTO_SEQUENCE_ENABLE_O;
	logic [5:0] PANEL_BOOST_VOLTAGE_FIELD_O, POSITIVE_RAIL_VOLTAGE_FIELD_O, NEGATIVE_RAIL_VOLTAGE_FIELD_O;
	logic [15:0] lfsr = 16'h0014;
	int mdl [64];
	int mflag = 0;
	int error_cnt = 0;
	int samples_checked = 0;
	// 200 MHz clock
	always #2.5 CLOCK_I = ~CLOCK_I;
	apb_host host_u (.clk_i(CLOCK_I), .psel_o(PSEL_I), .penable_o(PENABLE_I), .pwrite_o(PWRITE_I),
		.paddr_o(PADDR_I), .pwdata_o(PWDATA_I), .pstrb_o(PSTRB_I), .prdata_i(PRDATA_O), .pready_i(PREADY_O),
		.pslverr_i(PSLVERR_O), .hung_o(hung));
	bias_config_and_fault_flags #(.RAMP_SLOW_CYCLES(SLOW), .RAMP_FAST_CYCLES(FAST)) dut_u (.*,
		.BACKLIGHT_OVERVOLTAGE_FLAG_I(flt[7]), .FLASH_OVERVOLTAGE_FLAG_I(flt[6]),
		.FLASH_OUTPUT_SHORT_FLAG_I(flt[5]), .INPUT_MONITOR_FLAG_I(flt[4]), .FLASH_INTERRUPT_FLAG_I(flt[3]),
		.FLASH_LED_SHORT_FLAG_I(flt[2]), .FLASH_TIMEOUT_FLAG_I(flt[1]), .THERMAL_SHUTDOWN_FLAG_I(flt[0]),
		.PANEL_BOOST_OVERVOLTAGE_FLAG_I(flt[13]), .NEGATIVE_RAIL_OVERVOLTAGE_FLAG_I(flt[12]),
		.POSITIVE_RAIL_SHORT_FLAG_I(flt[11]), .NEGATIVE_RAIL_SHORT_FLAG_I(flt[10]),
		.FLASH_OVERCURRENT_FLAG_I(flt[9]), .BACKLIGHT_OVERCURRENT_FLAG_I(flt[8]),
		.POSITIVE_RAIL_ENABLE_PIN_I(pin_p), .NEGATIVE_RAIL_ENABLE_PIN_I(pin_n));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic xf(input logic wr, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		host_u.xfer(wr, {idx, 2'b00}, d, rd, err);
		if (hung) begin
			error_cnt++;
			give_verdict();
		end
	endtask : xf
	// Write, then update the model the way the rules say
	task automatic put(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		xf(1'b1, idx, d, rd, err);
		if (idx == `REG_IDX_BIAS_CFG) mdl[idx] = int'(d[7:0]);
		if (idx >= `REG_IDX_PANEL_CODE && idx <= `REG_IDX_NEG_CODE) mdl[idx] = int'(d[5:0]);
		if (idx == `REG_IDX_IRQ_ENABLE) mdl[idx] = int'(d[13:0]);
		if (idx == `REG_IDX_IRQ_CLEAR) mflag = mflag & ~int'(d[13:0]);
		@(negedge CLOCK_I);
	endtask : put
	task automatic get(input logic [5:0] idx, input logic experr);
		logic [31:0] rd;
		logic err;
		int ex;
		ex = (idx == `REG_IDX_FLAGS_PRI) ? (mflag & 255) : (idx == `REG_IDX_FLAGS_SEC) ? (mflag >> 8) : mdl[idx];
		xf(1'b0, idx, 32'h0000_0000, rd, err);
		`CHECK("read data", 32'(ex), rd)
		`CHECK("slave error", experr, err)
	endtask : get
	// Count cycles with the ramp flag up over a fixed window
	task automatic ramp(output int n);
		n = 0;
		repeat (3 * SLOW) begin
			@(negedge CLOCK_I);
			if (POSITIVE_RAIL_RAMPING_O === 1'b1) n++;
		end
	endtask : ramp
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int i;
		int n;
		flt = 14'h0000;
		pin_p = 1'b0;
		pin_n = 1'b0;
		mdl[`REG_IDX_BIAS_CFG] = `BIAS_CFG_RST;
		mdl[`REG_IDX_PANEL_CODE] = `PANEL_CODE_RST;
		mdl[`REG_IDX_POS_CODE] = `POS_CODE_RST;
		mdl[`REG_IDX_NEG_CODE] = `NEG_CODE_RST;
		repeat (16) @(posedge CLOCK_I);
		RESET_N_I <= 1'b1;
		for (i = 11; i <= 16; i++) get(6'(i), 1'b0);
		get(6'h20, 1'b1);
		`CHECK("cfg outputs", 5'b11000, {POSITIVE_DISCHARGE_O, NEGATIVE_DISCHARGE_O, WAKE_UP_ENABLE_O, POSITIVE_RAMP_TIME_SELECT_O, AUTO_SEQUENCE_ENABLE_O})
		$display("test reset finished");
		for (i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			put(6'(12 + i % 4), {lfsr, lfsr});
			if (i % 4 == 0) `CHECK("cfg bits", lfsr[7:5], {WAKE_UP_ENABLE_O, POSITIVE_RAMP_TIME_SELECT_O, AUTO_SEQUENCE_ENABLE_O})
			get(6'(12 + i % 4), 1'b0);
		end
		put(`REG_IDX_FLAGS_PRI, 32'hFFFF_FFFF);
		put(`REG_IDX_FLAGS_SEC, 32'hFFFF_FFFF);
		get(`REG_IDX_FLAGS_PRI, 1'b0);
		get(`REG_IDX_FLAGS_SEC, 1'b0);
		$display("test registers finished");
		put(`REG_IDX_BIAS_CFG, 32'h0000_0018);
		put(`REG_IDX_IRQ_ENABLE, 32'h0000_3FFF);
		for (i = 0; i < 14; i++) begin
			flt <= 14'(1 << i);
			repeat (8) @(posedge CLOCK_I);
			flt <= 14'h0000;
			mflag = 1 << i;
			repeat (8) @(posedge CLOCK_I);
			get(`REG_IDX_FLAGS_PRI, 1'b0);
			get(`REG_IDX_FLAGS_SEC, 1'b0);
			`CHECK("irq raised", 1'b1, IRQ_O)
			put(`REG_IDX_IRQ_ENABLE, 32'h0000_0000);
			@(negedge CLOCK_I);
			`CHECK("irq masked", 1'b0, IRQ_O)
			put(`REG_IDX_IRQ_ENABLE, 32'h0000_3FFF);
			put(`REG_IDX_IRQ_CLEAR, 32'(1 << i));
			get(`REG_IDX_FLAGS_PRI, 1'b0);
			get(`REG_IDX_FLAGS_SEC, 1'b0);
			`CHECK("irq cleared", 1'b0, IRQ_O)
		end
		$display("test faults finished");
		put(`REG_IDX_BIAS_CFG, 32'h0000_001C);
		ramp(n);
		`CHECK("slow ramp", 1'b1, n >= SLOW - 1 && n <= SLOW + 1)
		put(`REG_IDX_BIAS_CFG, 32'h0000_0018);
		@(negedge CLOCK_I);
		`CHECK("positive off", 2'b01, {POSITIVE_RAIL_ON_O, POSITIVE_DISCHARGE_O})
		put(`REG_IDX_BIAS_CFG, 32'h0000_005C);
		ramp(n);
		`CHECK("fast ramp", 1'b1, n >= FAST - 1 && n <= FAST + 1)
		put(`REG_IDX_BIAS_CFG, 32'h0000_0018);
		put(`REG_IDX_BIAS_CFG, 32'h0000_0026);
		`CHECK("negative held", 1'b0, NEGATIVE_RAIL_ON_O)
		ramp(n);
		`CHECK("negative after ramp", 1'b1, NEGATIVE_RAIL_ON_O)
		put(`REG_IDX_BIAS_CFG, 32'h0000_0000);
		@(negedge CLOCK_I);
		`CHECK("no discharge", 2'b00, {POSITIVE_DISCHARGE_O, NEGATIVE_DISCHARGE_O})
		put(`REG_IDX_BIAS_CFG, 32'h0000_001F);
		repeat (8) @(negedge CLOCK_I);
		`CHECK("bits ignored", 2'b00, {POSITIVE_RAIL_ON_O, NEGATIVE_RAIL_ON_O})
		@(posedge CLOCK_I);
		pin_p <= 1'b1;
		pin_n <= 1'b1;
		repeat (10) @(negedge CLOCK_I);
		`CHECK("pins drive", 2'b11, {POSITIVE_RAIL_ON_O, NEGATIVE_RAIL_ON_O})
		put(`REG_IDX_BIAS_CFG, 32'h0000_0018);
		@(negedge CLOCK_I);
		`CHECK("pins ignored", 2'b00, {POSITIVE_RAIL_ON_O, NEGATIVE_RAIL_ON_O})
		$display("test rails finished");
		give_verdict();
	end
endmodule : bias_config_and_fault_flags_tb_top
